// File: logic/duty_cap.v
// one pwm duty cap: limits the requested duty to the ceiling
`timescale 1ns/1ps

module duty_cap #(
   parameter W = 8
) (
   input wire clk,
   input wire reset_n,
   input wire [W-1:0] duty_req,
   input wire [W-1:0] ceiling,
   output reg [W-1:0] duty_out
);

always @(posedge clk) begin
   if (!reset_n) begin
      duty_out <= {W{1'b0}};
   end else if (duty_req > ceiling) begin
      duty_out <= ceiling;
   end else begin
      duty_out <= duty_req;
   end
end

endmodule // duty_cap

// File: logic/fan_monitor_config_status_regs.v
// configuration and limit-event registers of the fan and voltage monitor
//
// Local design decision: register access over APB.
`timescale 1ns/1ps
`include "fan_monitor_map.vh"

// Summary of operation
// RQ1 - three duty ceilings, reset full, cap outputs
// RQ2 - lock makes lockable registers ignore writes
// RQ3 - configuration resets with only run bit
// RQ4 - run selects programmed or default limits
// RQ5 - run bit frozen once lock written
// RQ6 - lock writable once, holds until reset
// RQ7 - ready bit shows device powered up
// RQ8 - full-speed bit forces fans, never locked
// RQ9 - lockable power-calculation flag kept
// RQ10 - spin-up check off drives full timeout
// RQ11 - bus timeout enable bit, lockable
// RQ12 - supply scaling selects 5 V or 3.3 V
// RQ13 - event register resets to zero
// RQ14 - bits 0-2 flag voltage limit violations
// RQ15 - read clears flag only if condition gone
// RQ16 - bit 3 flags 5 V or throttle timer
// RQ17 - bits 4-6 flag temperature limit violations
// RQ18 - bit 7 is OR of second bank
// RQ19 - host programs limits before setting run
// RQ20 - writing zero to lock does nothing
module fan_monitor_config_status_regs #(
   parameter DW = 8
) (
   input wire clk,
   input wire reset_n,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire [3:0] pstrb,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire powered_up,
   input wire [6:0] limit_fault,
   input wire thermal_throttle_pin,
   input wire throttle_timer_over,
   input wire [7:0] second_bank_flags,
   input wire [3*DW-1:0] duty_req,
   output wire [3*DW-1:0] duty_capped,
   output reg [3*DW-1:0] active_ceiling,
   output reg monitor_run,
   output reg fans_max_speed,
   output reg power_calc_enable,
   output reg spinup_check_off,
   output reg bus_timeout_on,
   output reg supply_5v_select,
   output reg device_ready,
   output reg locked
);

// ----------------------------------------------------------------------
// address decode
// ----------------------------------------------------------------------
function [2:0] decode;
   input [11:0] a;
   begin
      case (a)
         `ADDR_PWM1_CEIL: decode = 3'h1;
         `ADDR_PWM2_CEIL: decode = 3'h2;
         `ADDR_PWM3_CEIL: decode = 3'h3;
         `ADDR_MAIN_CFG: decode = 3'h4;
         `ADDR_EVT_FIRST: decode = 3'h5;
         default: decode = 3'h0;
      endcase
   end
endfunction

wire [2:0] sel = decode(paddr);
// zero-wait slave: setup then one access cycle; pready is registered
wire access = psel && penable && pready;
wire setup = psel && !penable;
wire wr = access && pwrite && pstrb[0] && (sel != 3'h0);
wire rd = access && !pwrite && (sel != 3'h0);
wire [7:0] wbyte = pwdata[7:0];

// ----------------------------------------------------------------------
// registers
// ----------------------------------------------------------------------
reg [DW-1:0] ceil_r [0:2];
reg [7:0] cfg_r;
reg [7:0] evt_r;
reg lock_r;
reg rdy_r;

// ----------------------------------------------------------------------
// duty ceilings
// ----------------------------------------------------------------------
// one write enable per channel; a locked bank ignores every write
wire [`PWM_CHANNELS-1:0] ceil_we;
reg [`PWM_CHANNELS*DW-1:0] ceil_nxt;
reg [`PWM_CHANNELS*DW-1:0] act_nxt;
integer k;
integer m;
integer n;

always @* begin
   for (k = 0; k < `PWM_CHANNELS; k = k + 1) begin
      if (ceil_we[k]) begin
         ceil_nxt[k*DW +: DW] = wbyte[DW-1:0];
      end else begin
         ceil_nxt[k*DW +: DW] = ceil_r[k];
      end
   end
end

// all channels share one process so the bank has a single driver
always @(posedge clk) begin
   for (n = 0; n < `PWM_CHANNELS; n = n + 1) begin
      if (!reset_n) begin
         ceil_r[n] <= `RST_CEIL; // see RQ1
      end else begin
         ceil_r[n] <= ceil_nxt[n*DW +: DW];
      end
   end
end

// default limits apply while not running; programmed values are kept
always @* begin
   for (m = 0; m < `PWM_CHANNELS; m = m + 1) begin
      if (cfg_r[`CFG_RUN]) begin // see RQ4
         act_nxt[m*DW +: DW] = ceil_r[m];
      end else begin
         act_nxt[m*DW +: DW] = `DEFAULT_CEIL;
      end
   end
end

always @(posedge clk) begin
   if (!reset_n) begin
      active_ceiling <= {`PWM_CHANNELS{`RST_CEIL}};
   end else begin
      active_ceiling <= act_nxt;
   end
end

genvar g;
generate
   for (g = 0; g < `PWM_CHANNELS; g = g + 1) begin : gen_ceil
      assign ceil_we[g] = wr && !lock_r && (sel == g + 1); // see RQ2
      duty_cap #(.W(DW)) u_cap (
         .clk(clk),
         .reset_n(reset_n),
         .duty_req(duty_req[g*DW +: DW]),
         .ceiling(active_ceiling[g*DW +: DW]),
         .duty_out(duty_capped[g*DW +: DW])
      ); // see RQ1
   end
endgenerate

// ----------------------------------------------------------------------
// main configuration
// ----------------------------------------------------------------------
// lock is sticky: a write of zero cannot release it, only reset
reg [7:0] cfg_nxt;
reg lock_nxt;
wire cfg_wr = wr && (sel == 3'h4);

always @* begin
   cfg_nxt = cfg_r;
   lock_nxt = lock_r;
   if (cfg_wr) begin
      cfg_nxt[`CFG_FANS_MAX_SPEED] = wbyte[`CFG_FANS_MAX_SPEED]; // see RQ8
      if (wbyte[`CFG_LOCK]) begin // see RQ6, RQ20
         lock_nxt = 1'b1;
      end
      if (!lock_r) begin // see RQ2, RQ5
         cfg_nxt[`CFG_RUN] = wbyte[`CFG_RUN];
         cfg_nxt[`CFG_PWR] = wbyte[`CFG_PWR]; // see RQ9
         cfg_nxt[`CFG_SPIN] = wbyte[`CFG_SPIN]; // see RQ10
         cfg_nxt[`CFG_TMO] = wbyte[`CFG_TMO]; // see RQ11
         cfg_nxt[`CFG_VSUP] = wbyte[`CFG_VSUP]; // see RQ12
      end
   end
end

always @(posedge clk) begin
   if (!reset_n) begin
      lock_r <= 1'b0;
      cfg_r <= `RST_MAIN_CFG; // see RQ3
   end else begin
      lock_r <= lock_nxt;
      cfg_r <= cfg_nxt;
   end
end

always @(posedge clk) begin
   if (!reset_n) begin
      rdy_r <= 1'b0;
   end else begin
      rdy_r <= powered_up; // see RQ7
   end
end

wire [7:0] cfg_view;
assign cfg_view = {cfg_r[7:3], rdy_r, lock_r, cfg_r[`CFG_RUN]};

always @(posedge clk) begin
   if (!reset_n) begin
      monitor_run <= 1'b1;
      fans_max_speed <= 1'b0;
      power_calc_enable <= 1'b0;
      spinup_check_off <= 1'b0;
      bus_timeout_on <= 1'b0;
      supply_5v_select <= 1'b0;
      device_ready <= 1'b0;
      locked <= 1'b0;
   end else begin
      monitor_run <= cfg_r[`CFG_RUN]; // see RQ4
      fans_max_speed <= cfg_r[`CFG_FANS_MAX_SPEED]; // see RQ8
      power_calc_enable <= cfg_r[`CFG_PWR]; // see RQ9
      spinup_check_off <= cfg_r[`CFG_SPIN]; // see RQ10
      bus_timeout_on <= cfg_r[`CFG_TMO]; // see RQ11
      supply_5v_select <= cfg_r[`CFG_VSUP]; // see RQ12
      device_ready <= rdy_r;
      locked <= lock_r;
   end
end

// ----------------------------------------------------------------------
// limit-event flags
// ----------------------------------------------------------------------
// bit 3 source switches with the throttle pin role
wire [6:0] cond;
assign cond = {limit_fault[6:4],
   thermal_throttle_pin ? throttle_timer_over : limit_fault[`EVT_5V],
   limit_fault[2:0]}; // see RQ14, RQ16, RQ17

wire evt_rd = rd && sel == 3'h5;

// a live condition keeps its flag set through the clearing read
reg [7:0] evt_nxt;
always @* begin
   evt_nxt = evt_r;
   evt_nxt[6:0] = cond | (evt_r[6:0] & {7{!evt_rd}}); // see RQ15
   evt_nxt[`EVT_SECOND] = |second_bank_flags; // see RQ18
end

always @(posedge clk) begin
   if (!reset_n) begin
      evt_r <= `RST_EVT_FIRST; // see RQ13
   end else begin
      evt_r <= evt_nxt;
   end
end

// ----------------------------------------------------------------------
// apb answer
// ----------------------------------------------------------------------
reg [7:0] rmux;
always @* begin
   case (sel)
      3'h1: rmux = ceil_r[0];
      3'h2: rmux = ceil_r[1];
      3'h3: rmux = ceil_r[2];
      3'h4: rmux = cfg_view;
      3'h5: rmux = evt_r;
      default: rmux = 8'h00;
   endcase
end

always @(posedge clk) begin
   if (!reset_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
   end else if (setup) begin
      pready <= 1'b1;
      pslverr <= (sel == 3'h0);
      prdata <= pwrite ? 32'h00000000 : {24'h000000, rmux};
   end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
   end
end

endmodule // fan_monitor_config_status_regs

// File: logic/fan_monitor_map.vh
// register offsets, bit positions and reset values of the monitor registers
`ifndef FAN_MONITOR_MAP_VH
`define FAN_MONITOR_MAP_VH

// register indices as printed; byte address is four times the index
`define IDX_PWM1_CEIL 8'h38
`define IDX_PWM2_CEIL 8'h39
`define IDX_PWM3_CEIL 8'h3a
`define IDX_MAIN_CFG 8'h40
`define IDX_EVT_FIRST 8'h41

`define ADDR_PWM1_CEIL 12'h0e0
`define ADDR_PWM2_CEIL 12'h0e4
`define ADDR_PWM3_CEIL 12'h0e8
`define ADDR_MAIN_CFG 12'h100
`define ADDR_EVT_FIRST 12'h104

`define RST_CEIL 8'hff
`define RST_MAIN_CFG 8'h01
`define RST_EVT_FIRST 8'h00
`define DEFAULT_CEIL 8'hff

`define CFG_RUN 0
`define CFG_LOCK 1
`define CFG_RDY 2
`define CFG_FANS_MAX_SPEED 3
`define CFG_PWR 4
`define CFG_SPIN 5
`define CFG_TMO 6
`define CFG_VSUP 7

`define EVT_2V5 0
`define EVT_CORE 1
`define EVT_VSUP 2
`define EVT_5V 3
`define EVT_SECOND 7

`define PWM_CHANNELS 3

`endif

// File: verif/fan_monitor_config_status_regs_tb_top.sv
// self-checking bench of the monitor register block
`timescale 1ns/1ps
module fan_monitor_config_status_regs_tb_top;
   reg clk = 0;
   reg reset_n = 0;
   reg powered_up = 0;
   reg [6:0] limit_fault = 0;
   reg thermal_throttle_pin = 0;
   reg throttle_timer_over = 0;
   reg [7:0] second_bank_flags = 0;
   reg [23:0] duty_req = 0;
   wire psel, penable, pwrite, pready, pslverr;
   wire [11:0] paddr;
   wire [31:0] pwdata, prdata;
   wire [23:0] duty_capped, active_ceiling;
   wire monitor_run, fans_max_speed, power_calc_enable, spinup_check_off;
   wire bus_timeout_on, supply_5v_select, device_ready, locked;
   integer fail_count = 0, cmp_count = 0, cyc = 0, i;
   reg [32:0] expq[$];
   reg [15:0] rs = 16'h76f3;
   reg [7:0] c[3];
   reg [7:0] e;
   always #4 clk = ~clk;
   host_apb u_host_apb (.clk, .pready, .psel, .penable, .pwrite, .paddr,
      .pwdata);
   fan_monitor_config_status_regs u_fan_monitor_config_status_regs (
      .clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata,
      .pstrb(4'hf), .prdata, .pready, .pslverr, .powered_up, .limit_fault,
      .thermal_throttle_pin, .throttle_timer_over, .second_bank_flags,
      .duty_req, .duty_capped, .active_ceiling, .monitor_run,
      .fans_max_speed, .power_calc_enable, .spinup_check_off,
      .bus_timeout_on, .supply_5v_select, .device_ready, .locked);
   function [15:0] lfsr(input [15:0] s);
      lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task chk(input string n, input [32:0] x, input [32:0] g);
      cmp_count = cmp_count + 1;
      if (x !== g) begin
         fail_count = fail_count + 1;
         $display("BAD %s exp %h got %h", n, x, g);
      end
   endtask
   task wr(input [11:0] a, input [7:0] d);
      u_host_apb.xfer(1, a, {24'h0, d});
      @(posedge clk);
   endtask
   task rd(input [11:0] a, input [32:0] x);
      expq.push_back(x);
      u_host_apb.xfer(0, a, 0);
      @(posedge clk);
   endtask
   task end_of_test;
      $display("compares %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // read data is settled by the falling edge of the access cycle
   always @(negedge clk)
      if (psel && penable && pready && !pwrite)
         chk("read", expq.pop_front(), {pslverr, prdata});
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         fail_count = fail_count + 1;
         end_of_test;
      end
   end
   initial begin
      repeat (5) @(posedge clk);
      reset_n <= 1;
      @(posedge clk);
      for (i = 0; i < 3; i++)
         rd(12'h0e0 + 12'(i * 4), 33'hff);
      rd(12'h100, 33'h01);
      rd(12'h104, 33'h00);
      powered_up <= 1;
      repeat (3) @(posedge clk);
      rd(12'h100, 33'h05);
      for (i = 0; i < 3; i++) begin
         rs = lfsr(rs);
         c[i] = rs[7:0];
         duty_req[i*8 +: 8] <= rs[15:8];
         wr(12'h0e0 + 12'(i * 4), c[i]);
      end
      for (i = 0; i < 3; i++) begin
         rd(12'h0e0 + 12'(i * 4), {25'h0, c[i]});
         e = duty_req[i*8 +: 8] < c[i] ? duty_req[i*8 +: 8] : c[i];
         chk("cap", e, duty_capped[i*8 +: 8]);
      end
      wr(12'h100, 8'h00);
      repeat (2) @(posedge clk);
      chk("dflt", 24'hffffff, active_ceiling);
      rd(12'h0e4, {25'h0, c[1]});
      wr(12'h100, 8'hf9);
      rd(12'h100, 33'hfd);
      chk("outs", 7'h7f, {monitor_run, fans_max_speed, power_calc_enable,
         spinup_check_off, bus_timeout_on, supply_5v_select,
         device_ready});
      limit_fault <= 7'h77;
      thermal_throttle_pin <= 1;
      throttle_timer_over <= 1;
      second_bank_flags <= 8'h10;
      repeat (3) @(posedge clk);
      rd(12'h104, 33'hff);
      limit_fault <= 7'h01;
      thermal_throttle_pin <= 0;
      throttle_timer_over <= 0;
      second_bank_flags <= 0;
      repeat (3) @(posedge clk);
      rd(12'h104, 33'h7f);
      rd(12'h104, 33'h01);
      rd(12'h200, {1'b1, 32'h0});
      wr(12'h100, 8'h13);
      wr(12'h0e0, 8'h11);
      wr(12'h100, 8'h08);
      rd(12'h0e0, {25'h0, c[0]});
      rd(12'h100, 33'h1f);
      chk("lock", 1'b1, locked);
      end_of_test;
   end
endmodule // fan_monitor_config_status_regs_tb_top

// File: verif/fan_regs_asserts.sv
// port assertions of the monitor register block
`timescale 1ns/1ps
module fan_regs_checker #(parameter DW = 8) (
   input wire clk,
   input wire reset_n,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   input wire powered_up,
   input wire [6:0] limit_fault,
   input wire [7:0] second_bank_flags,
   input wire [3*DW-1:0] duty_capped,
   input wire [3*DW-1:0] active_ceiling,
   input wire monitor_run,
   input wire power_calc_enable,
   input wire device_ready,
   input wire locked
);
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   wire rd_ev = psel && penable && pready && !pwrite && paddr == 12'h104;
   AST_ERR: assert property (pslverr |-> pready && !(paddr inside
      {12'h0e0, 12'h0e4, 12'h0e8, 12'h100, 12'h104})) else $error("err");
   AST_CAP: assert property (
      duty_capped[7:0] <= $past(active_ceiling[7:0])) else $error("cap");
   AST_DEF: assert property (
      !monitor_run && $past(!monitor_run) |-> &active_ceiling)
      else $error("default ceiling");
   AST_LOCK: assert property (locked |=> locked)
      else $error("lock lost");
   AST_FROZEN: assert property (
      locked && $past(locked) |->
      $stable({monitor_run, power_calc_enable, active_ceiling}))
      else $error("locked value moved");
   AST_READY: assert property (
      $rose(powered_up) |-> ##[1:3] device_ready) else $error("ready");
   AST_OR: assert property (
      (second_bank_flags != 0) [*3] ##0 rd_ev |-> prdata[7])
      else $error("second bank");
   AST_FLAG: assert property (
      limit_fault[0] [*3] ##0 rd_ev |-> prdata[0]) else $error("flag");
   cover property (rd_ev && prdata[7]);
   cover property ($rose(locked));
   cover property (pslverr);
endmodule // fan_regs_checker
bind fan_monitor_config_status_regs fan_regs_checker #(.DW(DW)) u_chk (
   .clk, .reset_n, .psel, .penable, .pwrite, .paddr, .prdata, .pready,
   .pslverr, .powered_up, .limit_fault, .second_bank_flags, .duty_capped,
   .active_ceiling, .monitor_run, .power_calc_enable, .device_ready,
   .locked);

// File: verif/host_apb_model.sv
// host-side apb master model for the monitor registers
`timescale 1ns/1ps
module host_apb (
   input wire clk,
   input wire pready,
   output reg psel = 0,
   output reg penable = 0,
   output reg pwrite = 0,
   output reg [11:0] paddr = 0,
   output reg [31:0] pwdata = 0
);
   // request held until pready at an edge; write data then inverted
   // so a late sample never sees a stale match
   task xfer(input w, input [11:0] a, input [31:0] d);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1;
      @(posedge clk);
      while (!pready) @(posedge clk);
      psel <= 0;
      penable <= 0;
      pwdata <= ~d;
   endtask
endmodule // host_apb
